// File: iwc_pkg.sv
// Purpose: Shared constants and types for the interrupt and wake control block.
// Assumes: One 8-bit control register on the parallel register port.
// Notes:   Field positions follow the control register layout.
package iwc_pkg;

  // Register map and reset value.
  localparam logic [7:0] IWC_CTRL_ADDR  = 8'h2C;
  localparam logic [7:0] IWC_CTRL_RESET = 8'h00;
  localparam logic [7:0] IWC_READ_ZERO  = 8'h00;

  // Field positions inside the control register.
  localparam int IWC_HOLD_BIT  = 7;
  localparam int IWC_WAKE_MSB  = 6;
  localparam int IWC_WAKE_LSB  = 2;
  localparam int IWC_POL_BIT   = 1;
  localparam int IWC_DRIVE_BIT = 0;

  // Acceleration event functions: 0 vector magnitude, 1 freefall/motion,
  // 2 pulse, 3 orientation, 4 transient; index i maps to register bit i+2.
  localparam int IWC_FUNC_W = 5;
  localparam int IWC_MAG_W  = 2;
  localparam int IWC_RATE_W = 3;

  // Buffer gate state.
  typedef enum logic [0:0] {
    IWC_GATE_PASS = 1'b0,
    IWC_GATE_HELD = 1'b1
  } iwc_gate_t;

  // Pin level for a logical interrupt request under a given polarity.
  function automatic logic iwc_pin_level(input logic asserted, input logic active_high);
    iwc_pin_level = asserted ? active_high : ~active_high;
  endfunction : iwc_pin_level

endpackage : iwc_pkg

// File: iwc_irq_if.sv
// Purpose: Carries interrupt line requests and pin configuration to the pin driver.
// Assumes: All signals are synchronous to the block clock.
// Notes:   The control side drives, the pin driver only reads.
`timescale 1ns/1ps
interface iwc_irq_if;
  logic active_high; // Polarity select from the control register.
  logic open_drain;  // Drive type select from the control register.
  logic req_one;     // Logical request for the first interrupt line.
  logic req_two;     // Logical request for the second interrupt line.

  modport ctl (output active_high, output open_drain, output req_one, output req_two);
  modport drv (input active_high, input open_drain, input req_one, input req_two);
endinterface : iwc_irq_if

// File: iwc_irq_pin.sv
// Purpose: Registered drivers for the two interrupt output pins.
// Assumes: Requests arrive as active-high logical levels.
// Notes:   Output enable high means the pin is driven.
`timescale 1ns/1ps
module iwc_irq_pin (
  input  wire logic clk,         // Block clock.
  input  wire logic rstn,        // Asynchronous reset, active low.
  iwc_irq_if.drv    cfg,         // Requests and pin configuration.
  output logic      line_one_o,  // First interrupt line level.
  output logic      line_one_oe, // First interrupt line drive enable.
  output logic      line_two_o,  // Second interrupt line level.
  output logic      line_two_oe  // Second interrupt line drive enable.
);
  import iwc_pkg::*;

  // Levels follow the polarity bit; the default is active low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_one_o <= 1'b1;
      line_two_o <= 1'b1;
    end else begin
      line_one_o <= iwc_pin_level(cfg.req_one, cfg.active_high);
      line_two_o <= iwc_pin_level(cfg.req_two, cfg.active_high);
    end
  end

  // Open drain drives only while asserted so several sources can share a wire.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_one_oe <= 1'b1;
      line_two_oe <= 1'b1;
    end else begin
      line_one_oe <= ~cfg.open_drain | cfg.req_one;
      line_two_oe <= ~cfg.open_drain | cfg.req_two;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  pol_level_a: assert property (
    line_one_oe |-> line_one_o == ($past(cfg.req_one) == $past(cfg.active_high)))
    else $error("Interrupt line one level does not match polarity and request.");

  pp_drive_a: assert property (
    !cfg.open_drain |=> line_one_oe && line_two_oe)
    else $error("Push-pull interrupt line was released.");

  od_release_a: assert property (
    cfg.open_drain && !cfg.req_two |=> !line_two_oe)
    else $error("Open-drain interrupt line driven while not asserted.");

endmodule : iwc_irq_pin

// File: iwc_ctrl.sv
// Purpose: Interrupt and wake control register with buffer gating on mode change.
// Assumes: Inputs are synchronous to clk; the buffer reports empty as a level.
// Notes:   Buffer gate, sleep wake enables and interrupt pin setup.
// Operation
// - Hold bit clear: flush the sample buffer on every sleep/wake change.
// - Hold bit set: keep buffer across change, drop samples until emptied.
// - While held, a sample arriving before emptying raises the overrun flag.
// - Overrun flag stays while buffer unemptied, clears once emptied.
// - Bit 6 keeps transient detection running and waking in sleep.
// - Bit 5 keeps orientation detection running and waking in sleep.
// - Bit 4 keeps pulse detection running and waking in sleep.
// - Bit 3 keeps freefall/motion detection running and waking in sleep.
// - Bit 2 keeps vector-magnitude detection running and waking in sleep.
// - Bit 1 picks interrupt line polarity: 0 active low, 1 active high.
// - Bit 0 picks interrupt drive: 0 push-pull, 1 open drain.
// - Flush the sample buffer when the output sample rate changes, except in the cycle of a mode change with the hold bit set.
// - Control register at 0x2C holds eight read/write bits, reset zero.
// - Magnetic wake enables come from separate registers, not this one.
// - With auto-sleep on, each sleep/wake change clears debounce counters.
`timescale 1ns/1ps
module iwc_ctrl (
  input  wire logic                          clk,             // Block clock, 20 MHz.
  input  wire logic                          rstn,            // Asynchronous reset, active low.
  input  wire logic [7:0]                    reg_addr,        // Register address.
  input  wire logic [7:0]                    reg_wdata,       // Register write data.
  input  wire logic                          reg_wr,          // Write strobe, one cycle.
  input  wire logic                          reg_rd,          // Read strobe, one cycle.
  output logic      [7:0]                    reg_rdata,       // Read data, held until next read.
  input  wire logic                          sys_wake,        // System mode: 1 wake, 0 sleep.
  input  wire logic                          auto_sleep_en,   // Auto-sleep enable.
  input  wire logic [iwc_pkg::IWC_RATE_W-1:0] output_sample_rate, // System sample rate code.
  input  wire logic                          sample_in,       // New sample offered, pulse.
  input  wire logic                          buf_empty,       // Sample buffer is empty.
  input  wire logic [iwc_pkg::IWC_FUNC_W-1:0] acc_event,      // Acceleration event flags.
  input  wire logic [iwc_pkg::IWC_MAG_W-1:0]  mag_event,      // Magnetic event flags.
  input  wire logic [iwc_pkg::IWC_MAG_W-1:0]  mag_wake_en,    // Magnetic wake enables.
  input  wire logic                          irq_one_req,     // Request for line one.
  input  wire logic                          irq_two_req,     // Request for line two.
  output logic                               buf_flush,       // Flush the buffer, pulse.
  output logic                               sample_push,     // Write sample to buffer, pulse.
  output logic                               hold_overrun,    // Overrun flag for mode register.
  output logic                               debounce_clr,    // Clear debounce counters, pulse.
  output logic      [iwc_pkg::IWC_FUNC_W-1:0] func_active,    // Event functions allowed to run.
  output logic                               wake_req,        // Wake the system, pulse.
  output logic                               irq_line_one_o,  // Line one level.
  output logic                               irq_line_one_oe, // Line one drive enable.
  output logic                               irq_line_two_o,  // Line two level.
  output logic                               irq_line_two_oe  // Line two drive enable.
);
  import iwc_pkg::*;

  logic [7:0]            interrupt_wake_control_r;
  logic                  wake_q_r;
  logic [IWC_RATE_W-1:0] rate_q_r;
  logic                  primed_r;
  iwc_gate_t             gate_r;
  iwc_gate_t             gate_nxt;
  logic                  hold_en;
  logic                  mode_chg;
  logic                  rate_chg;
  logic                  hold_start;
  logic                  held_now;
  logic [IWC_FUNC_W-1:0] sleep_keep;
  logic                  ctrl_hit;

  assign ctrl_hit   = (reg_addr == IWC_CTRL_ADDR);
  assign hold_en    = interrupt_wake_control_r[IWC_HOLD_BIT];
  assign sleep_keep = interrupt_wake_control_r[IWC_WAKE_MSB:IWC_WAKE_LSB];

  // Control register: all eight bits writable, cleared by reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_wake_control_r <= IWC_CTRL_RESET;
    end else if (reg_wr && ctrl_hit) begin
      interrupt_wake_control_r <= reg_wdata;
    end
  end

  // Read port; any other address reads as zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= IWC_READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= ctrl_hit ? interrupt_wake_control_r : IWC_READ_ZERO;
    end
  end

  // Previous mode and rate. The first cycle after reset only captures, so
  // an input that differs from a reset constant is not seen as a change.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_q_r <= 1'b0;
      rate_q_r <= '0;
      primed_r <= 1'b0;
    end else begin
      wake_q_r <= sys_wake;
      rate_q_r <= output_sample_rate;
      primed_r <= 1'b1;
    end
  end

  assign mode_chg   = primed_r && (sys_wake != wake_q_r);
  assign rate_chg   = primed_r && (output_sample_rate != rate_q_r);
  // An empty buffer has nothing to preserve, so the gate is not closed.
  assign hold_start = mode_chg && hold_en && !buf_empty;
  // The gate acts from the transition cycle itself, not one cycle later.
  assign held_now   = (gate_r == IWC_GATE_HELD) || hold_start;

  // Gate state: closes on a held transition, opens once the host empties it.
  always_comb begin
    gate_nxt = gate_r;
    unique case (gate_r)
      IWC_GATE_PASS: begin
        if (hold_start) begin
          gate_nxt = IWC_GATE_HELD;
        end
      end
      IWC_GATE_HELD: begin
        if (buf_empty) begin
          gate_nxt = IWC_GATE_PASS;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_r <= IWC_GATE_PASS;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // Flush on a plain mode change or a rate change. A rate change that comes
  // with a held mode change does not flush, or holding would be pointless.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_flush <= 1'b0;
    end else begin
      buf_flush <= (mode_chg && !hold_en)
                || (rate_chg && !(mode_chg && hold_en));
    end
  end

  // Samples pass to the buffer unless the gate holds it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_push <= 1'b0;
    end else begin
      sample_push <= sample_in && !held_now;
    end
  end

  // Overrun flag: set by a sample while held, cleared by an empty buffer.
  // The set term needs a non-empty buffer, so set and clear never collide.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_overrun <= 1'b0;
    end else if (held_now && sample_in && !buf_empty) begin
      hold_overrun <= 1'b1;
    end else if (buf_empty) begin
      hold_overrun <= 1'b0;
    end
  end

  // Debounce counters restart on each transition under auto-sleep only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debounce_clr <= 1'b0;
    end else begin
      debounce_clr <= auto_sleep_en && mode_chg;
    end
  end

  // In wake every function runs; in sleep only those kept by their bit.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      func_active <= '1;
    end else begin
      func_active <= sys_wake ? '1 : sleep_keep;
    end
  end

  // Wake request from kept acceleration functions or enabled magnetic ones;
  // the magnetic enables live in other registers and arrive as inputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= !sys_wake && ((|(acc_event & sleep_keep))
                             || (|(mag_event & mag_wake_en)));
    end
  end

  // Pin configuration and requests travel to the registered pin driver.
  iwc_irq_if irq_bus ();
  assign irq_bus.active_high = interrupt_wake_control_r[IWC_POL_BIT];
  assign irq_bus.open_drain  = interrupt_wake_control_r[IWC_DRIVE_BIT];
  assign irq_bus.req_one     = irq_one_req;
  assign irq_bus.req_two     = irq_two_req;

  iwc_irq_pin u_pin (
    .clk         (clk),
    .rstn        (rstn),
    .cfg         (irq_bus),
    .line_one_o  (irq_line_one_o),
    .line_one_oe (irq_line_one_oe),
    .line_two_o  (irq_line_two_o),
    .line_two_oe (irq_line_two_oe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  flush_mode_a: assert property (
    mode_chg && !hold_en |=> buf_flush)
    else $error("Mode change without hold did not flush the buffer.");

  held_drop_a: assert property (
    held_now && sample_in |=> !sample_push)
    else $error("Sample pushed while the buffer was held.");

  overrun_set_a: assert property (
    held_now && sample_in && !buf_empty |=> hold_overrun)
    else $error("Overrun flag not raised by sample while held.");

  overrun_keep_a: assert property (
    hold_overrun && !buf_empty |=> hold_overrun ##0 $stable(hold_overrun))
    else $error("Overrun flag dropped while buffer still unemptied.");

  overrun_clear_a: assert property (
    buf_empty |=> !hold_overrun)
    else $error("Overrun flag not cleared by empty buffer.");

  sleep_funcs_a: assert property (
    !sys_wake ##1 !$past(reg_wr) |-> func_active == $past(sleep_keep))
    else $error("Sleep function enables do not follow the control register.");

  rate_flush_a: assert property (
    rate_chg && !mode_chg |=> buf_flush)
    else $error("Sample rate change did not flush the buffer.");

  ctrl_write_a: assert property (
    reg_wr && ctrl_hit ##1 reg_rd && ctrl_hit && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Control register did not read back the written value.");

  mag_wake_a: assert property (
    !sys_wake && |(mag_event & mag_wake_en) |=> wake_req)
    else $error("Enabled magnetic event in sleep did not request wake.");

  debounce_a: assert property (
    mode_chg |=> debounce_clr == $past(auto_sleep_en))
    else $error("Debounce clear does not match auto-sleep on transition.");

  // Gate checks. A rate change may still flush while held, so only the
  // held transition itself is required to leave the buffer alone.
  hold_noflush_a: assert property (
    hold_start && !rate_chg |=> !buf_flush)
    else $error("Held mode change flushed the buffer.");

  push_pass_a: assert property (
    sample_in && !held_now |=> sample_push)
    else $error("Sample not pushed while the gate was open.");

  gate_close_a: assert property (
    hold_start |=> gate_r == IWC_GATE_HELD)
    else $error("Gate did not close on a held mode change.");

  gate_open_a: assert property (
    gate_r == IWC_GATE_HELD && buf_empty |=> gate_r == IWC_GATE_PASS)
    else $error("Gate did not open once the buffer was emptied.");

  flush_idle_a: assert property (
    !mode_chg && !rate_chg |=> !buf_flush)
    else $error("Buffer flushed without a mode or rate change.");

  debounce_idle_a: assert property (
    !mode_chg |=> !debounce_clr)
    else $error("Debounce clear without a mode change.");

  // Wake and register port checks.
  wake_funcs_a: assert property (
    sys_wake |=> &func_active)
    else $error("An event function was stopped while awake.");

  acc_wake_a: assert property (
    !sys_wake && |(acc_event & sleep_keep) |=> wake_req)
    else $error("Kept acceleration event in sleep did not request wake.");

  awake_quiet_a: assert property (
    sys_wake |=> !wake_req)
    else $error("Wake request raised while already awake.");

  wr_land_a: assert property (
    reg_wr && ctrl_hit |=> interrupt_wake_control_r == $past(reg_wdata))
    else $error("Control register write did not land.");

  other_addr_a: assert property (
    reg_rd && !ctrl_hit |=> reg_rdata == IWC_READ_ZERO)
    else $error("Unmapped read did not return zero.");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read strobe.");

endmodule : iwc_ctrl

// File: iwc_host.sv
// Purpose: Host model that reaches the control register over the strobe port.
// Assumes: Callers enter a task just after a rising clock edge.
// Notes:   Idle address and data lines flip so stale values are never trusted.
`timescale 1ns/1ps
module iwc_host (
  input  wire logic       clk,       // Block clock.
  output logic      [7:0] reg_addr,  // Register address.
  output logic      [7:0] reg_wdata, // Write data.
  output logic            reg_wr,    // Write strobe.
  output logic            reg_rd,    // Read strobe.
  input  wire logic [7:0] reg_rdata  // Read data.
);
  // Bus starts idle with both strobes low.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // A released bus shows the inverse of its last value, not a helpful copy.
  // Only a raised strobe is released, so back-to-back calls never set a line twice.
  task automatic release_bus;
    if (reg_wr || reg_rd) begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
    end
  endtask : release_bus

  // One-cycle write, taken at the next rising edge; the strobe is left up.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    reg_rd    = 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_write

  // One-cycle read; data is registered at the edge that takes the strobe.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    reg_wr   = 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : reg_read
endmodule : iwc_host

// File: testbench.sv
// Purpose: Self-checking bench for the interrupt and wake control block.
// Assumes: Outputs settle one cycle after their cause; checks wait longer.
// Notes:   Pulses are counted on the falling edge to avoid edge races.
`timescale 1ns/1ps
module testbench;
  import iwc_pkg::*;
  logic       clk  = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d;
  logic       reg_wr, reg_rd, sys_wake, auto_sleep_en, sample_in, buf_empty;
  logic [2:0] rate;
  logic [4:0] acc_event, func_active;
  logic [1:0] mag_event, mag_wake_en;
  logic       req1, req2, buf_flush, sample_push, hold_overrun, debounce_clr;
  logic       wake_req, o1, oe1, o2, oe2;
  int         n_mismatch, n_checks, n_flush, n_push, n_clr, seed;

  always #25 clk = ~clk;

  iwc_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  iwc_ctrl dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_wake(sys_wake), .auto_sleep_en(auto_sleep_en),
    .output_sample_rate(rate), .sample_in(sample_in), .buf_empty(buf_empty),
    .acc_event(acc_event), .mag_event(mag_event), .mag_wake_en(mag_wake_en),
    .irq_one_req(req1), .irq_two_req(req2), .buf_flush(buf_flush),
    .sample_push(sample_push), .hold_overrun(hold_overrun),
    .debounce_clr(debounce_clr), .func_active(func_active), .wake_req(wake_req),
    .irq_line_one_o(o1), .irq_line_one_oe(oe1),
    .irq_line_two_o(o2), .irq_line_two_oe(oe2));

  // Count single-cycle pulses midway through each cycle.
  always @(negedge clk) begin
    n_flush += (buf_flush === 1'b1);
    n_push  += (sample_push === 1'b1);
    n_clr   += (debounce_clr === 1'b1);
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Releases the register port, then settles just after the n-th edge.
  task automatic step(input int n);
    host_u.release_bus();
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Expected wake request: only in sleep, from kept or enabled events.
  function automatic logic wake_exp(input logic wake, input logic [7:0] r);
    wake_exp = !wake && ((|(acc_event & r[6:2])) || (|(mag_event & mag_wake_en)));
  endfunction : wake_exp

  // Clears the pulse counters before a stimulus window.
  task automatic zero_counts;
    n_flush = 0;
    n_push  = 0;
    n_clr   = 0;
  endtask : zero_counts

  // Expected pin pair {level, enable} for one request.
  function automatic logic [1:0] pin_exp(input logic req, input logic [7:0] r);
    pin_exp = {req ? r[1] : ~r[1], ~r[0] | req};
  endfunction : pin_exp

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Watchdog sized well beyond the roughly 155 cycles the sequence needs.
  initial begin
    #(3000 * 50);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 32'h8c09c58c;
    {sys_wake, auto_sleep_en, sample_in, buf_empty, req1, req2} = 6'b100100;
    {rate, acc_event, mag_event, mag_wake_en} = '0;
    step(3);
    chk({func_active, o1, oe1, o2}, 8'hFF);
    chk(reg_rdata, 8'h00);
    chk({2'b00, buf_flush, sample_push, debounce_clr, wake_req, oe2, hold_overrun}, 8'h02);
    rstn = 1'b1;
    step(2);
    host_u.reg_read(8'h2C, v);
    chk(v, 8'h00);
    host_u.reg_write(8'h2C, 8'hFF);
    host_u.reg_read(8'h2C, v);
    chk(v, 8'hFF);
    host_u.reg_write(8'h2D, 8'h00);
    host_u.reg_read(8'h2C, v);
    chk(v, 8'hFF);
    host_u.reg_read(8'h2D, v);
    chk(v, 8'h00);
    // Gate bypassed: every mode or rate change flushes once.
    host_u.reg_write(8'h2C, 8'h00);
    zero_counts();
    auto_sleep_en = 1'b1;
    sys_wake = 1'b0;
    step(4);
    chk(8'(n_flush), 8'h01);
    chk(8'(n_clr), 8'h01);
    zero_counts();
    rate = 3'h5;
    step(4);
    chk(8'(n_flush), 8'h01);
    // Gate held: no flush, samples dropped and overrun kept until emptied.
    host_u.reg_write(8'h2C, 8'h80);
    buf_empty = 1'b0;
    zero_counts();
    sys_wake = 1'b1;
    step(2);
    sample_in = 1'b1;
    step(1);
    sample_in = 1'b0;
    step(2);
    chk(8'(n_flush), 8'h00);
    chk(8'(n_push), 8'h00);
    chk(8'(hold_overrun), 8'h01);
    step(4);
    chk(8'(hold_overrun), 8'h01);
    buf_empty = 1'b1;
    step(2);
    chk(8'(hold_overrun), 8'h00);
    sample_in = 1'b1;
    step(1);
    sample_in = 1'b0;
    step(2);
    chk(8'(n_push), 8'h01);
    // Random settings with the all-kept and none-kept sleep wake corner cases first.
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'h7F : (i == 1) ? 8'h03 : 8'($random(seed));
      host_u.reg_write(8'h2C, d);
      {auto_sleep_en, sys_wake, req1, req2, acc_event, mag_event, mag_wake_en} =
        13'($random(seed));
      step(3);
      chk(8'(func_active), 8'(sys_wake ? 5'h1F : d[6:2]));
      chk(8'(wake_req), 8'(wake_exp(sys_wake, d)));
      chk(8'({o1, oe1}), 8'(pin_exp(req1, d)));
      chk(8'({o2, oe2}), 8'(pin_exp(req2, d)));
      host_u.reg_read(8'h2C, v);
      chk(v, d);
    end
    print_verdict();
  end
endmodule : testbench
